//--- src/srpm_pkg.sv
// constants and types for the refresh and power-mode block
package srpm_pkg;

    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP     = 4'h7;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_DPD     = 4'h6;
    localparam logic [3:0] CMD_INH_BIT = 4'h8;

    localparam int unsigned CLK_MHZ        = 25;
    localparam int unsigned SELF_TICK_NS   = 7800;
    localparam int unsigned SELF_TICK_CYC  = (SELF_TICK_NS * CLK_MHZ) / 1000;
    localparam int unsigned RFC_NS         = 72;
    localparam int unsigned RFC_CYC        = (RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ROW_BITS       = 13;

    typedef enum logic [2:0] {
        SRPM_ACTIVE,
        SRPM_POWER_DOWN,
        SRPM_SELF_REFRESH,
        SRPM_DEEP_POWER_DOWN,
        SRPM_CLOCK_SUSPEND
    } srpm_state_t;

endpackage : srpm_pkg

//--- src/srpm_tick.sv
`timescale 1ns/1ps
// internal self-refresh oscillator stand-in: periodic pulse while enabled
module srpm_tick
    import srpm_pkg::*;
#(
    parameter int unsigned PERIOD = SELF_TICK_CYC
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_run,
    output logic      o_tick
);
    localparam int unsigned W = (PERIOD > 1) ? $clog2(PERIOD) : 1;

    initial begin
        if (PERIOD < 1) $error("srpm_tick: PERIOD must be at least 1");
    end

    logic [W-1:0] count;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            o_tick <= 1'b0;
            if (!i_run) begin
                count <= '0;
            end else if (count == W'(PERIOD - 1)) begin
                count  <= '0;
                o_tick <= 1'b1;
            end else begin
                count <= count + W'(1);
            end
        end
    end

endmodule : srpm_tick

//--- src/srpm_top.sv
`timescale 1ns/1ps
// refresh, power-down, deep power-down and clock-suspend state handling
module srpm_top
    import srpm_pkg::*;
#(
    parameter int unsigned ROWS_W   = ROW_BITS,
    parameter int unsigned TICK_CYC = SELF_TICK_CYC
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    input  wire logic              i_cke,
    input  wire logic              i_cs_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic              i_any_open,
    input  wire logic              i_burst_busy,
    output logic [2:0]             o_state,
    output logic                   o_refresh_pulse,
    output logic [ROWS_W-1:0]      o_refresh_row,
    output logic                   o_buffers_on,
    output logic                   o_internal_clk_en,
    output logic                   o_array_powered,
    output logic                   o_active_pd,
    output logic                   o_need_init
);
    initial begin
        if (ROWS_W < 1 || ROWS_W > 16) $error("srpm_top: ROWS_W out of range");
        if (TICK_CYC < RFC_CYC) $error("srpm_top: TICK_CYC below refresh cycle");
    end

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    logic [6:0] pin_meta;
    logic [6:0] pin_sync;

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            // idle level: clock enable high, command inhibit
            pin_meta <= 7'h4F;
            pin_sync <= 7'h4F;
        end else if (i_ce) begin
            pin_meta <= {i_cke, i_any_open, i_burst_busy, i_cs_n, i_ras_n, i_cas_n, i_we_n};
            pin_sync <= pin_meta;
        end
    end

    logic       cke;
    logic       any_open;
    logic       burst_busy;
    logic [3:0] cmd;

    assign cke        = pin_sync[6];
    assign any_open   = pin_sync[5];
    assign burst_busy = pin_sync[4];
    assign cmd        = pin_sync[3:0];

    function automatic logic is_idle_cmd(input logic [3:0] c);
        is_idle_cmd = c[3] || (c == CMD_NOP);
    endfunction : is_idle_cmd

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    srpm_state_t state;
    srpm_state_t next_state;
    logic        self_tick;
    logic        rfc_busy;

    always_comb begin
        next_state = state;
        unique case (state)
            SRPM_ACTIVE: begin
                if (!cke && burst_busy) begin
                    next_state = SRPM_CLOCK_SUSPEND;
                end else if (!cke && cmd == CMD_REFRESH && !any_open) begin
                    next_state = SRPM_SELF_REFRESH;
                end else if (!cke && cmd == CMD_DPD && !any_open) begin
                    next_state = SRPM_DEEP_POWER_DOWN;
                end else if (!cke && is_idle_cmd(cmd) && !rfc_busy) begin
                    next_state = SRPM_POWER_DOWN;
                end
            end
            SRPM_POWER_DOWN: begin
                if (cke && is_idle_cmd(cmd)) next_state = SRPM_ACTIVE;
            end
            SRPM_SELF_REFRESH: begin
                if (cke) next_state = SRPM_ACTIVE;
            end
            SRPM_DEEP_POWER_DOWN: begin
                if (cke) next_state = SRPM_ACTIVE;
            end
            SRPM_CLOCK_SUSPEND: begin
                if (cke) next_state = SRPM_ACTIVE;
            end
            default: next_state = SRPM_ACTIVE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SRPM_ACTIVE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // refresh row counter and refresh cycle timing
    // ------------------------------------------------------------
    localparam int unsigned RW = (RFC_CYC > 1) ? $clog2(RFC_CYC + 1) : 1;

    logic [RW-1:0] rfc_count;
    logic          auto_ref;
    logic          do_refresh;

    assign auto_ref   = (state == SRPM_ACTIVE) && cke && (cmd == CMD_REFRESH) && !rfc_busy;
    assign do_refresh = auto_ref || (state == SRPM_SELF_REFRESH && self_tick && !rfc_busy);
    assign rfc_busy   = (rfc_count != '0);

    srpm_tick #(
        .PERIOD (TICK_CYC)
    ) u_tick (
        .i_mclk (i_mclk),
        .i_rst_n(rst_n),
        .i_ce   (i_ce),
        .i_run  (state == SRPM_SELF_REFRESH),
        .o_tick (self_tick)
    );

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            rfc_count <= '0;
        end else if (i_ce) begin
            if (do_refresh) begin
                rfc_count <= RW'(RFC_CYC);
            end else if (rfc_busy) begin
                rfc_count <= rfc_count - RW'(1);
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_refresh_row   <= '0;
            o_refresh_pulse <= 1'b0;
        end else if (i_ce) begin
            o_refresh_pulse <= do_refresh;
            if (do_refresh) begin
                o_refresh_row <= o_refresh_row + ROWS_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_state <= 3'h0;
        end else if (i_ce) begin
            o_state <= next_state;
        end
    end

    // buffers stay on only while active or in clock suspend
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_buffers_on <= 1'b1;
        end else if (i_ce) begin
            o_buffers_on <= (next_state == SRPM_ACTIVE) ||
                            (next_state == SRPM_CLOCK_SUSPEND);
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_internal_clk_en <= 1'b1;
        end else if (i_ce) begin
            o_internal_clk_en <= (next_state == SRPM_ACTIVE);
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_array_powered <= 1'b1;
        end else if (i_ce) begin
            o_array_powered <= (next_state != SRPM_DEEP_POWER_DOWN);
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_active_pd <= 1'b0;
        end else if (i_ce) begin
            if (state == SRPM_ACTIVE && next_state == SRPM_POWER_DOWN) begin
                o_active_pd <= any_open;
            end else if (next_state != SRPM_POWER_DOWN) begin
                o_active_pd <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_need_init <= 1'b0;
        end else if (i_ce) begin
            if (next_state == SRPM_DEEP_POWER_DOWN) begin
                o_need_init <= 1'b1;
            end else if (state == SRPM_ACTIVE && cke && cmd == CMD_REFRESH) begin
                o_need_init <= 1'b0;
            end
        end
    end

endmodule : srpm_top

//--- verif/srpm_properties.sv
`timescale 1ns/1ps
// port-level assertions for the refresh and power-mode block
module srpm_properties
    import srpm_pkg::*;
#(
    parameter int unsigned ROWS_W = ROW_BITS
) (
    input wire logic              i_mclk,
    input wire logic              i_rst_n,
    input wire logic              i_ce,
    input wire logic              i_cke,
    input wire logic              i_cs_n,
    input wire logic              i_ras_n,
    input wire logic              i_cas_n,
    input wire logic              i_we_n,
    input wire logic              i_any_open,
    input wire logic              i_burst_busy,
    input wire logic [2:0]        o_state,
    input wire logic              o_refresh_pulse,
    input wire logic [ROWS_W-1:0] o_refresh_row,
    input wire logic              o_buffers_on,
    input wire logic              o_internal_clk_en,
    input wire logic              o_array_powered,
    input wire logic              o_active_pd,
    input wire logic              o_need_init
);
    // ----------------------------------------
    // checks, pins seen three edges later
    // ----------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    wire [3:0] cmd  = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    wire       idle = i_cs_n | (cmd == CMD_NOP);

    a_row_step: assert property ($changed(o_refresh_row) |->
        o_refresh_row == $past(o_refresh_row) + 1'b1) else $error("row counter jumped");
    a_sr_quiet: assert property (o_state == SRPM_SELF_REFRESH |->
        !o_buffers_on && !o_internal_clk_en) else $error("self refresh not quiet");
    a_pd_quiet: assert property (o_state == SRPM_POWER_DOWN && $past(o_state) == o_state
        |-> !o_buffers_on && !o_refresh_pulse) else $error("power-down active");
    a_dpd_dark: assert property (o_state == SRPM_DEEP_POWER_DOWN |->
        !o_array_powered && o_need_init) else $error("deep power-down array on");
    a_dpd_entry: assert property (o_state == SRPM_ACTIVE && $past(cmd, 2) == CMD_DPD
        && !$past(i_cke, 2) && !$past(i_any_open, 2) && !$past(i_burst_busy, 2)
        |=> o_state == SRPM_DEEP_POWER_DOWN) else $error("deep power-down missed");
    a_pd_kind: assert property ($past(o_state) == SRPM_ACTIVE && o_state == SRPM_POWER_DOWN
        |-> o_active_pd == $past(i_any_open, 3)) else $error("power-down kind wrong");
    a_pd_exit: assert property (o_state == SRPM_POWER_DOWN && $past(i_cke, 2)
        && $past(idle, 2) |=> o_state == SRPM_ACTIVE) else $error("power-down exit missed");
    a_susp_hold: assert property (o_state == SRPM_CLOCK_SUSPEND |->
        !o_internal_clk_en && !$past(i_cke, 3)) else $error("suspend wrong");
    a_susp_exit: assert property (o_state == SRPM_CLOCK_SUSPEND && $past(i_cke, 2)
        |=> o_state == SRPM_ACTIVE) else $error("suspend exit missed");

    c_self: cover property (o_state == SRPM_SELF_REFRESH);
    c_deep: cover property (o_state == SRPM_DEEP_POWER_DOWN);
    c_susp: cover property (o_state == SRPM_CLOCK_SUSPEND);
endmodule : srpm_properties

bind srpm_top srpm_properties #(.ROWS_W(ROWS_W)) u_props (.i_mclk, .i_rst_n, .i_ce,
    .i_cke, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n, .i_any_open, .i_burst_busy, .o_state,
    .o_refresh_pulse, .o_refresh_row, .o_buffers_on, .o_internal_clk_en,
    .o_array_powered, .o_active_pd, .o_need_init);

//--- verif/srpm_ctrl_model.sv
`timescale 1ns/1ps
// memory controller stand-in driving clock enable and command pins
module srpm_ctrl_model
    import srpm_pkg::*;
(
    input  wire logic i_mclk,
    output logic      o_cke,
    output logic      o_cs_n,
    output logic      o_ras_n,
    output logic      o_cas_n,
    output logic      o_we_n
);
    initial {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke} = {CMD_NOP, 1'b1};
    // one command for one cycle, then nop with the given clock enable
    task automatic send(input logic k, input logic [3:0] c, input logic ka);
        @(negedge i_mclk);
        o_cke = k;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
        @(negedge i_mclk);
        o_cke = ka;
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
    endtask : send
endmodule : srpm_ctrl_model

//--- verif/srpm_top_tb.sv
`timescale 1ns/1ps
// self-checking bench for the refresh and power-mode block
module srpm_top_tb;
    import srpm_pkg::*;
    localparam int TK = 8;
    logic i_mclk = 0, i_rst_n = 0, i_any_open = 0, i_burst_busy = 0, i_ce = 1;
    logic i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n;
    logic [2:0] o_state;
    logic [12:0] o_refresh_row;
    logic o_refresh_pulse, o_buffers_on, o_internal_clk_en, o_array_powered;
    logic o_active_pd, o_need_init;
    int fails = 0, n_compared = 0, pulses = 0, m_st = 0, p0;

    srpm_ctrl_model ctl (.i_mclk, .o_cke(i_cke), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n),
        .o_cas_n(i_cas_n), .o_we_n(i_we_n));
    srpm_top #(.TICK_CYC(TK)) dut (.i_mclk, .i_rst_n, .i_ce, .i_cke, .i_cs_n,
        .i_ras_n, .i_cas_n, .i_we_n, .i_any_open, .i_burst_busy, .o_state,
        .o_refresh_pulse, .o_refresh_row, .o_buffers_on, .o_internal_clk_en,
        .o_array_powered, .o_active_pd, .o_need_init);

    initial forever #20 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_refresh_pulse === 1'b1 && i_ce === 1'b1) pulses++;

    // ----------------------------------------
    // reference model and checking
    // ----------------------------------------
    function automatic int nxt(int s, logic k, logic [3:0] c);
        logic idle = c[3] || c == CMD_NOP;
        if (s == 0 && !k) begin
            if (i_burst_busy) return 4;
            if (c == CMD_REFRESH && !i_any_open) return 2;
            if (c == CMD_DPD && !i_any_open) return 3;
            return idle ? 1 : 0;
        end
        if (s != 0 && k && (s != 1 || idle)) return 0;
        return s;
    endfunction : nxt
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic go(input logic k, input logic [3:0] c, input logic ka);
        m_st = nxt(nxt(m_st, k, c), ka, CMD_NOP);
        ctl.send(k, c, ka);
        repeat (4) @(negedge i_mclk);
        check("state", o_state, m_st[2:0]);
        check("buffers", o_buffers_on, m_st == 0 || m_st == 4);
        check("int clock", o_internal_clk_en, m_st == 0);
        check("array", o_array_powered, m_st != 3);
    endtask : go

    initial begin
        void'($urandom(32'hD8C0));
        repeat (12) @(negedge i_mclk);
        i_rst_n = 1;
        repeat (3) @(negedge i_mclk);
        repeat (3) begin
            p0 = pulses;
            go(1, CMD_REFRESH, 1);
            check("refresh", pulses - p0, 1);
        end
        go(0, CMD_DPD, 0);
        check("need init", o_need_init, 1);
        go(1, CMD_NOP, 1);
        go(1, CMD_REFRESH, 1);
        check("init done", o_need_init, 0);
        go(0, CMD_REFRESH, 0);
        p0 = pulses;
        repeat (4 * TK) @(negedge i_mclk);
        check("self ticks", pulses - p0, 4);
        i_ce = 0;
        p0 = pulses;
        repeat (2 * TK) @(negedge i_mclk);
        i_ce = 1;
        check("frozen ticks", pulses - p0, 0);
        check("frozen state", o_state, m_st[2:0]);
        go(1, CMD_NOP, 1);
        repeat (4) begin
            i_any_open = 1'($urandom);
            go(0, CMD_NOP, 0);
            check("active pd", o_active_pd, i_any_open);
            p0 = pulses;
            repeat (2 * TK) @(negedge i_mclk);
            go(1, CMD_REFRESH, 0);
            check("pd refresh", pulses - p0, 0);
            go(1, {1'($urandom), 3'h7}, 1);
        end
        i_any_open = 0;
        i_burst_busy = 1;
        go(0, CMD_NOP, 0);
        p0 = pulses;
        go(0, CMD_REFRESH, 0);
        check("suspend refresh", pulses - p0, 0);
        go(1, CMD_NOP, 1);
        i_burst_busy = 0;
        check("row", o_refresh_row, pulses[12:0]);
        print_verdict();
    end
    initial begin
        #50us;
        fails++;
        print_verdict();
    end
endmodule : srpm_top_tb
